//--- prdc_pkg.sv
package prdc_pkg;
  localparam int          LINES      = 23;
  localparam int          FUNC_W     = 3;
  localparam int          LINE_TCK   = 0;
  localparam int          LINE_TMS   = 1;
  localparam int          LINE_TDI   = 2;
  localparam int          LINE_TDO   = 3;
  localparam int          LINE_RC    = 20;
  localparam logic [2:0]  FUNC_F     = 3'h5;
  localparam logic [2:0]  FUNC_TWI   = 3'h0;
  localparam logic [22:0] TWI_MASK   = 23'h2200a0;
  localparam logic [22:0] PULL_RST   = 23'h000001;
  localparam logic [22:0] GPIO_RST   = 23'h4dff5f;
  localparam logic [22:0] OE_RST     = 23'h000000;
  localparam logic [22:0] OUT_RST    = 23'h000000;
endpackage

//--- prdc_pin_control.sv
// Notes on behaviour
// RQ1: JTAG enables only if TCK samples low when reset releases.
// RQ2: JTAG enabled: pull-ups on TCK, TMS, TDI; TDO driven, no pull-up.
// RQ3: TCK pull-up stays on during the whole of reset.
// RQ4: JTAG disabled: its pins work as GPIO or peripheral lines.
// RQ5: Software uses port line zero as GPIO output only.
// RQ6: Two-wire capable pins select I2C function out of reset.
// RQ7: I2C assigned pins are open-drain with input spike filter.
// RQ8: Every line has a pull-up, enabled separately per line.
// RQ9: After reset lines are inputs, pull-ups off, except line zero.
// RQ10: After reset line twenty selects function F, clock output on.
// RQ11: Slow RC clock drives line twenty from power-up, even in reset.
// RQ12: Clock output stops on GPIO, other function, or keep bit zero.
// RQ13: Once stopped, the slow RC clock output never restarts; the code restarts it on power-on reset.
// RQ14: Software stops the clock output before alternate crystal output.
// RQ15: Analog input path blocked while the line drives high.
// RQ16: Clock-output stop flag cleared only by power-on reset.
`timescale 1ns/1ns
module prdc_pin_control #(
  parameter int LINES = prdc_pkg::LINES
) (
  input  wire logic                   clock,
  input  wire logic                   rst,
  input  wire logic                   porRst,
  input  wire logic [LINES-1:0]       padIn,
  input  wire logic                   rcClkIn,
  input  wire logic                   cfgWr,
  input  wire logic [4:0]             cfgLine,
  input  wire logic                   cfgGpio,
  input  wire logic [2:0]             cfgFunc,
  input  wire logic                   cfgPull,
  input  wire logic                   cfgOe,
  input  wire logic                   cfgOut,
  input  wire logic                   keepRcWr,
  input  wire logic                   keepRcVal,
  input  wire logic [LINES-1:0]       periphOut,
  input  wire logic [LINES-1:0]       periphOe,
  input  wire logic                   jtagTdo,
  input  wire logic [LINES-1:0]       adcReq,
  output logic      [LINES-1:0]       padOut_q,
  output logic      [LINES-1:0]       padOe_q,
  output logic      [LINES-1:0]       padPull_q,
  output logic      [LINES-1:0]       lineIn_q,
  output logic      [LINES-1:0]       adcEn_q,
  output logic                        jtagEn_q,
  output logic                        rcOutOn_q
);
  if (LINES != prdc_pkg::LINES) begin : gBadLines
    $error("LINES must match the pad map");
  end

  logic [LINES-1:0] syncA_q;
  logic [LINES-1:0] syncB_q;
  logic [LINES-1:0] syncC_q;
  logic             rcA_q;
  logic             rcB_q;
  logic             rstPrev_q;
  logic             rcDis_q;
  logic [LINES-1:0] gpioSel_q;
  logic [LINES-1:0] pullCfg_q;
  logic [LINES-1:0] oeCfg_q;
  logic [LINES-1:0] outCfg_q;
  logic [LINES*3-1:0] func_q;
  logic [LINES-1:0] twiMode_q;
  logic [LINES-1:0] padOut_d;
  logic [LINES-1:0] padOe_d;
  logic [LINES-1:0] padPull_d;
  logic [LINES-1:0] twiMode_d;
  logic             rcOn_d;

  // Pads and the oscillator are asynchronous to clock
  always_ff @(posedge clock) begin
    syncA_q <= padIn;
    syncB_q <= syncA_q;
    syncC_q <= syncB_q;
    rcA_q   <= rcClkIn;
    rcB_q   <= rcA_q;
  end

  // Sample TCK on the cycle reset goes away
  always_ff @(posedge clock) begin
    if (porRst) begin
      rstPrev_q <= 1'b1;
      jtagEn_q  <= 1'b0;
    end else begin
      rstPrev_q <= rst;
      if (rstPrev_q && !rst) begin
        jtagEn_q <= !syncB_q[prdc_pkg::LINE_TCK]; // RQ1
      end
    end
  end

  // Line configuration, written one line at a time
  always_ff @(posedge clock) begin
    if (rst || porRst) begin
      gpioSel_q <= prdc_pkg::GPIO_RST; // RQ6
      pullCfg_q <= prdc_pkg::PULL_RST; // RQ9
      oeCfg_q   <= prdc_pkg::OE_RST; // RQ9
      outCfg_q  <= prdc_pkg::OUT_RST;
      for (int i = 0; i < LINES; i++) begin
        func_q[i*3 +: 3] <= (i == prdc_pkg::LINE_RC) ?
                            prdc_pkg::FUNC_F : prdc_pkg::FUNC_TWI; // RQ10
      end
    end else if (cfgWr && (int'(cfgLine) < LINES)) begin
      gpioSel_q[cfgLine]      <= cfgGpio;
      pullCfg_q[cfgLine]      <= cfgPull; // RQ8
      oeCfg_q[cfgLine]        <= cfgOe;
      outCfg_q[cfgLine]       <= cfgOut;
      func_q[cfgLine*3 +: 3]  <= cfgFunc;
    end
  end

  // Sticky stop flag survives system reset, only power-on clears it
  always_ff @(posedge clock) begin
    if (porRst) begin
      rcDis_q <= 1'b0; // RQ16
    end else if (!rst && (gpioSel_q[prdc_pkg::LINE_RC] ||
               func_q[prdc_pkg::LINE_RC*3 +: 3] != prdc_pkg::FUNC_F ||
               (keepRcWr && !keepRcVal))) begin
      rcDis_q <= 1'b1; // RQ12
    end
  end

  // Clock runs on line twenty through power-on reset too
  assign rcOn_d = !rcDis_q && !(keepRcWr && !keepRcVal); // RQ11 RQ13

  genvar g;
  generate
    for (g = 0; g < LINES; g++) begin : gLine
      localparam bit IS_TWI = prdc_pkg::TWI_MASK[g];
      localparam bit IS_JIN = (g == prdc_pkg::LINE_TCK) ||
                              (g == prdc_pkg::LINE_TMS) ||
                              (g == prdc_pkg::LINE_TDI);
      always_comb begin
        twiMode_d[g] = 1'b0;
        padPull_d[g] = pullCfg_q[g];
        if (jtagEn_q && !rst && IS_JIN) begin
          padOe_d[g]   = 1'b0;
          padOut_d[g]  = 1'b0;
          padPull_d[g] = 1'b1; // RQ2
        end else if (jtagEn_q && !rst && g == prdc_pkg::LINE_TDO) begin
          padOe_d[g]   = 1'b1;
          padOut_d[g]  = jtagTdo;
          padPull_d[g] = 1'b0; // RQ2
        end else if (g == prdc_pkg::LINE_RC && rcOn_d) begin
          padOe_d[g]  = 1'b1;
          padOut_d[g] = rcB_q; // RQ11
        end else if (gpioSel_q[g]) begin
          padOe_d[g]  = oeCfg_q[g]; // RQ4
          padOut_d[g] = outCfg_q[g];
        end else if (IS_TWI && func_q[g*3 +: 3] == prdc_pkg::FUNC_TWI) begin
          twiMode_d[g] = 1'b1;
          padOe_d[g]   = periphOe[g] && !periphOut[g]; // RQ7
          padOut_d[g]  = 1'b0;
        end else begin
          padOe_d[g]  = periphOe[g]; // RQ4
          padOut_d[g] = periphOut[g];
        end
        if (rst && g == prdc_pkg::LINE_TCK) begin
          padPull_d[g] = 1'b1; // RQ3
        end
      end

      always_ff @(posedge clock) begin
        if (porRst) begin
          lineIn_q[g] <= 1'b1;
        end else if (!twiMode_q[g]) begin
          lineIn_q[g] <= syncB_q[g];
        end else if (syncB_q[g] == syncC_q[g]) begin
          lineIn_q[g] <= syncB_q[g]; // RQ7
        end
      end
    end
  endgenerate

  always_ff @(posedge clock) begin
    if (porRst) begin
      padOut_q  <= '0;
      padOe_q   <= '0;
      padPull_q <= prdc_pkg::PULL_RST;
      twiMode_q <= '0;
      adcEn_q   <= '0;
      rcOutOn_q <= 1'b1;
      padOe_q[prdc_pkg::LINE_RC] <= 1'b1;
      // Clock must reach the pad while power-on reset still holds
      padOut_q[prdc_pkg::LINE_RC] <= rcB_q; // RQ11
    end else begin
      padOut_q  <= padOut_d;
      padOe_q   <= padOe_d;
      padPull_q <= padPull_d;
      twiMode_q <= twiMode_d;
      adcEn_q   <= adcReq & ~(padOe_d & padOut_d); // RQ15
      rcOutOn_q <= rcOn_d;
    end
  end

  a_tck_pull_reset: assert property ( // RQ3
    @(posedge clock) disable iff (porRst)
    rst |=> padPull_q[prdc_pkg::LINE_TCK])
    else $error("TCK pull-up dropped in reset");

  a_jtag_sample_tck: assert property ( // RQ1
    @(posedge clock) disable iff (porRst)
    (rstPrev_q && !rst) |=>
      (jtagEn_q == !$past(syncB_q[prdc_pkg::LINE_TCK])))
    else $error("JTAG enable not taken from TCK at release");

  a_jtag_pin_setup: assert property ( // RQ2
    @(posedge clock) disable iff (porRst)
    (jtagEn_q && !rst) |=> (padPull_q[prdc_pkg::LINE_TCK] &&
      padPull_q[prdc_pkg::LINE_TMS] && padPull_q[prdc_pkg::LINE_TDI] &&
      !padPull_q[prdc_pkg::LINE_TDO] && padOe_q[prdc_pkg::LINE_TDO] &&
      padOut_q[prdc_pkg::LINE_TDO] == $past(jtagTdo)))
    else $error("JTAG pin setup wrong");

  a_reset_defaults: assert property ( // RQ9
    @(posedge clock) disable iff (porRst)
    rst |=> (gpioSel_q == prdc_pkg::GPIO_RST &&
             pullCfg_q == prdc_pkg::PULL_RST && oeCfg_q == '0))
    else $error("Line defaults wrong after reset");

  a_rc_stop_sticky: assert property ( // RQ13
    @(posedge clock) disable iff (porRst)
    rcDis_q |=> rcDis_q [*3])
    else $error("Clock output stop flag cleared");

  a_rc_keep_zero: assert property ( // RQ12
    @(posedge clock) disable iff (porRst)
    (keepRcWr && !keepRcVal && !rst) |=> (rcDis_q && !rcOutOn_q))
    else $error("Keep bit zero did not stop clock output");

  a_rc_out_off: assert property ( // RQ13
    @(posedge clock) disable iff (porRst)
    rcDis_q |=> !rcOutOn_q)
    else $error("Clock output on after stop");

  a_rc_power_up: assert property ( // RQ11
    @(posedge clock)
    $fell(porRst) |-> (rcOutOn_q && padOe_q[prdc_pkg::LINE_RC]))
    else $error("Clock output absent at power-up");

  a_adc_block: assert property ( // RQ15
    @(posedge clock) disable iff (porRst)
    (adcEn_q & padOe_q & padOut_q) == '0)
    else $error("Analog path open while driving high");

  a_twi_open_drain: assert property ( // RQ7
    @(posedge clock) disable iff (porRst)
    (twiMode_q & padOe_q & padOut_q) == '0)
    else $error("Two-wire line driven high");
endmodule // prdc_pin_control

//--- prdc_board.sv
`timescale 1ns/1ns
module prdc_board (
  input  wire logic        clock,
  input  wire logic        tckLow,
  input  wire logic [22:0] padOut_q,
  input  wire logic [22:0] padOe_q,
  input  wire logic [22:0] padPull_q,
  output logic      [22:0] padIn,
  output logic             rcClkIn
);
  logic [22:0] floatPat_q = 23'h0;
  logic [3:0]  rcDiv_q = 4'h0;
  // Undriven pads toggle so a missing pull-up never looks settled
  always_ff @(posedge clock) floatPat_q <= ~floatPat_q;
  // Slow oscillator scaled down to keep runs short
  always_ff @(posedge clock) rcDiv_q <= rcDiv_q + 4'h1;
  assign rcClkIn = rcDiv_q[3];
  always_comb begin
    padIn = (padOe_q & padOut_q) | (~padOe_q & padPull_q)
          | (~padOe_q & ~padPull_q & floatPat_q);
    if (tckLow) padIn[0] = 1'b0;
  end
endmodule // prdc_board

//--- test_pin_reset_default_control.sv
`timescale 1ns/1ns
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin fails++; \
  $display("MISMATCH %0t got %h exp %h", $time, a, e); end end
module test_pin_reset_default_control;
  logic        clock, rst, porRst, rcClkIn, cfgWr, cfgGpio, cfgPull, cfgOe;
  logic        cfgOut, keepRcWr, keepRcVal, jtagTdo, tckLow, jtagEn_q;
  logic        rcOutOn_q, oe, rcHi, rcLo;
  logic [4:0]  cfgLine;
  logic [2:0]  cfgFunc;
  logic [22:0] padIn, periphOut, periphOe, adcReq, padOut_q, padOe_q;
  logic [22:0] padPull_q, adcEn_q, lineIn_q;
  logic [31:0] seed, r;
  int          fails, check_count, l;
  prdc_pin_control u_prdc_pin_control (.clock(clock), .rst(rst),
    .porRst(porRst), .padIn(padIn), .rcClkIn(rcClkIn), .cfgWr(cfgWr),
    .cfgLine(cfgLine), .cfgGpio(cfgGpio), .cfgFunc(cfgFunc),
    .cfgPull(cfgPull), .cfgOe(cfgOe), .cfgOut(cfgOut),
    .keepRcWr(keepRcWr), .keepRcVal(keepRcVal), .periphOut(periphOut),
    .periphOe(periphOe), .jtagTdo(jtagTdo), .adcReq(adcReq),
    .padOut_q(padOut_q), .padOe_q(padOe_q), .padPull_q(padPull_q),
    .lineIn_q(lineIn_q), .adcEn_q(adcEn_q), .jtagEn_q(jtagEn_q),
    .rcOutOn_q(rcOutOn_q));
  prdc_board u_prdc_board (.clock(clock), .tckLow(tckLow),
    .padOut_q(padOut_q), .padOe_q(padOe_q), .padPull_q(padPull_q),
    .padIn(padIn), .rcClkIn(rcClkIn));
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Analog path only while the line is not driven high
  function automatic logic expAdc(input logic o, input logic v);
    return !(o && v);
  endfunction
  task automatic wr(input int ln, input logic g, input logic [2:0] f,
                    input logic p, input logic o, input logic v);
    cfgWr = 1'b1;
    cfgLine = ln[4:0];
    {cfgGpio, cfgFunc, cfgPull, cfgOe, cfgOut} = {g, f, p, o, v};
    @(negedge clock);
    cfgWr = 1'b0;
    repeat (2) @(negedge clock);
  endtask
  task automatic rstSeq(input logic por);
    rst = 1'b1;
    porRst = por;
    repeat (16) @(negedge clock);
    rst = 1'b0;
    porRst = 1'b0;
    repeat (6) @(negedge clock);
  endtask
  task automatic results();
    $display("fails=%0d check_count=%0d", fails, check_count);
    if (fails == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial begin
    seed = 32'h5b;
    {cfgWr, keepRcWr, keepRcVal, cfgGpio, cfgPull, cfgOe, cfgOut} = '0;
    {cfgLine, cfgFunc, jtagTdo, periphOut, periphOe} = '0;
    adcReq = '1;
    tckLow = 1'b1;
    rst = 1'b1;
    porRst = 1'b1;
    {rcHi, rcLo} = 2'b00;
    // Slow clock must toggle on the pad while power-on reset holds
    for (int i = 0; i < 16; i++) begin
      @(negedge clock);
      rcHi = rcHi | padOut_q[prdc_pkg::LINE_RC];
      rcLo = rcLo | !padOut_q[prdc_pkg::LINE_RC];
    end
    `CHK({rcHi, rcLo}, 2'h3)
    `CHK(padPull_q[0], 1'b1)
    `CHK(rcOutOn_q, 1'b1)
    {rst, porRst} = 2'b00;
    jtagTdo = 1'b1;
    for (int i = 0; i < 10 && jtagEn_q !== 1'b1; i++) @(negedge clock);
    `CHK(jtagEn_q, 1'b1)
    // Pad setup follows the enable by one edge
    @(negedge clock);
    `CHK(padPull_q[3:0], 4'h7)
    `CHK({padOe_q[3], padOut_q[3]}, 2'h3)
    tckLow = 1'b0;
    rstSeq(1'b1);
    `CHK(jtagEn_q, 1'b0)
    `CHK(padPull_q, prdc_pkg::PULL_RST)
    `CHK(padOe_q[19:0], 20'h0)
    `CHK({rcOutOn_q, padOe_q[20]}, 2'h3)
    periphOe = prdc_pkg::TWI_MASK;
    repeat (3) @(negedge clock);
    `CHK(padOe_q & periphOe, periphOe)
    periphOut = prdc_pkg::TWI_MASK;
    repeat (3) @(negedge clock);
    `CHK(padOe_q & periphOe, 23'h0)
    // Released lines float and toggle; the filter must hold them low
    repeat (2) @(negedge clock);
    for (int i = 0; i < 3; i++) begin
      @(negedge clock);
      `CHK(lineIn_q & prdc_pkg::TWI_MASK, 23'h0)
    end
    for (int i = 0; i < 30; i++) begin
      r = xs();
      l = int'(r[3:0]);
      oe = r[5] || l == 0;
      jtagTdo = r[7];
      wr(l, 1'b1, r[10:8], r[4], oe, r[6]);
      `CHK(padPull_q[l], r[4])
      `CHK(padOe_q[l], oe)
      if (oe) `CHK(padOut_q[l], r[6])
      `CHK(adcEn_q[l], expAdc(oe, r[6]))
      repeat (3) @(negedge clock);
      if (oe || r[4]) `CHK(lineIn_q[l], oe ? r[6] : 1'b1)
    end
    wr(20, 1'b0, 3'h2, 1'b0, 1'b0, 1'b0);
    `CHK(rcOutOn_q, 1'b0)
    wr(20, 1'b0, prdc_pkg::FUNC_F, 1'b0, 1'b0, 1'b0);
    `CHK(rcOutOn_q, 1'b0)
    rstSeq(1'b0);
    `CHK(rcOutOn_q, 1'b0)
    rstSeq(1'b1);
    `CHK(rcOutOn_q, 1'b1)
    wr(20, 1'b1, prdc_pkg::FUNC_F, 1'b0, 1'b0, 1'b0);
    `CHK(rcOutOn_q, 1'b0)
    rstSeq(1'b1);
    keepRcVal = 1'b1;
    keepRcWr = 1'b1;
    @(negedge clock);
    {keepRcWr, keepRcVal} = 2'b00;
    @(negedge clock);
    `CHK(rcOutOn_q, 1'b1)
    // Clock output stopped before any crystal use of the line
    keepRcWr = 1'b1;
    @(negedge clock);
    keepRcWr = 1'b0;
    `CHK(rcOutOn_q, 1'b0)
    results();
  end
endmodule // test_pin_reset_default_control
